// File: src/pcg_pkg.sv
// Register map, field positions, constants and state types of the CRC generator.
package pcg_pkg;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFS_MASK_LOW = 8'h08;
  localparam logic [7:0] OFS_MASK_HIGH = 8'h0c;
  localparam logic [7:0] OFS_DATA_LOW = 8'h10;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h14;
  localparam logic [7:0] OFS_RES_LOW = 8'h18;
  localparam logic [7:0] OFS_RES_HIGH = 8'h1c;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int EN_BIT = 15;
  localparam int VW_LSB = 8;
  localparam int FULL_BIT = 7;
  localparam int EMPTY_BIT = 6;
  localparam int ISEL_BIT = 5;
  localparam int GO_BIT = 4;
  localparam int DIR_BIT = 3;
  localparam int DW_LSB = 8;
  localparam int PLEN_LSB = 0;
  localparam int FIELD_W = 5;
  localparam int HALF_W = 16;
  localparam int BYTE_W = 8;

  // ---------------------------------------------------------------------------
  // Engine and FIFO constants
  // ---------------------------------------------------------------------------
  localparam int BITS_PER_CYCLE = 2;
  localparam int FIFO_WORDS = 16;
  localparam logic [4:0] DW_WIDE_ABOVE = 5'h0f;
  localparam logic [4:0] DW_MID_FROM = 5'h08;
  localparam logic [4:0] DEPTH_WIDE = 5'h04;
  localparam logic [4:0] DEPTH_MID = 5'h08;
  localparam logic [4:0] DEPTH_NARROW = 5'h10;
  localparam logic [4:0] TOP_BIT = 5'h1f;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [5:0] LEFT_ONE = 6'h01;
  localparam logic [3:0] PTR_ONE = 4'h1;
  localparam logic [31:0] CONST_TERM = 32'h00000001;
  localparam logic [31:0] ALL_ONES = 32'hffffffff;

  typedef enum logic {ENG_IDLE, ENG_SHIFT} pcg_eng_e;

  typedef struct packed {
    logic en;
    logic isel;
    logic dir;
    logic go;
    logic [4:0] dw;
    logic [4:0] plen;
    logic [31:0] mask;
    logic [31:0] crc;
    logic [31:0] stage;
    logic [FIFO_WORDS-1:0][31:0] mem;
    logic [3:0] wp;
    logic [3:0] rp;
    logic [4:0] cnt;
    logic [31:0] sh;
    logic [5:0] left;
    pcg_eng_e eng;
    logic [31:0] rdata;
    logic irq;
  } pcg_state_s;

endpackage : pcg_pkg

// File: src/pcg_crc_top.sv
// Programmable CRC generator with input FIFO and APB register slave.
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps

// Contract
// - Polynomial order comes from order field.
// - Set mask bit applies XOR there.
// - Constant term always applied; bit zero ignored.
// - Order 32 implies the top term.
// - Data width is width field plus one.
// - FIFO depth four, eight or sixteen.
// - Byte writes; bits above width ignored.
// - Count increments when width MSb written.
// - Shift only with start set, data present.
// - Word moves to buffer, count decrements.
// - Two bits shifted per cycle.
// - Full at depth, empty at zero.
// - Disable empties FIFO, count held zero.
// - MSb first, or LSb first when selected.
// - Direction never reflects the result.
// - Select zero: interrupt on count one-to-zero.
// - Select one: interrupt on hardware completion.
// - Software clearing start raises no interrupt.
// - Empty interrupt precedes final bits shifting.
// - Order field holds length minus one.
// - Data pair fills FIFO, reads zero.
// - Result pair loads and reads shifter.
// - Start bit clears itself on completion.
module pcg_crc_top (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic IRQ_OUT
);

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------
  function automatic logic [4:0] fifo_depth(input logic [4:0] dw);
    logic [4:0] d;
    if (dw > pcg_pkg::DW_WIDE_ABOVE) begin
      d = pcg_pkg::DEPTH_WIDE;
    end else if (dw >= pcg_pkg::DW_MID_FROM) begin
      d = pcg_pkg::DEPTH_MID;
    end else begin
      d = pcg_pkg::DEPTH_NARROW;
    end
    return d;
  endfunction : fifo_depth

  function automatic logic [15:0] merge_half(input logic [15:0] old,
                                             input logic [15:0] wd,
                                             input logic [1:0] be);
    logic [15:0] r;
    r = old;
    for (int b = 0; b < 2; b++) begin
      if (be[b]) begin
        r[b*pcg_pkg::BYTE_W +: pcg_pkg::BYTE_W] = wd[b*pcg_pkg::BYTE_W +: pcg_pkg::BYTE_W];
      end
    end
    return r;
  endfunction : merge_half

  // One bit through a plain, unreflected shifter of order plen + 1.
  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic [31:0] m,
                                           input logic [4:0] pl,
                                           input logic d);
    logic [31:0] lm;
    logic fb;
    logic [31:0] nc;
    lm = pcg_pkg::ALL_ONES >> (pcg_pkg::TOP_BIT - pl);
    fb = d ^ c[pl];
    nc = (c << 1) & lm;
    if (fb) begin
      nc = nc ^ ((m | pcg_pkg::CONST_TERM) & lm);
    end
    return nc;
  endfunction : crc_step

  function automatic logic next_bit(input logic [31:0] sh,
                                    input logic [4:0] dw,
                                    input logic dir);
    return dir ? sh[0] : sh[dw];
  endfunction : next_bit

  function automatic logic [31:0] shift_buf(input logic [31:0] sh, input logic dir);
    return dir ? (sh >> 1) : (sh << 1);
  endfunction : shift_buf

  // ---------------------------------------------------------------------------
  // State and bus decode
  // ---------------------------------------------------------------------------
  pcg_pkg::pcg_state_s state_reg;
  pcg_pkg::pcg_state_s state_next;
  logic acc_wr;
  logic rd_setup;
  logic mapped;
  logic [4:0] depth;
  logic full;
  logic hit_data;
  logic push;
  logic pop;
  logic wr_ctrl_one;
  logic [31:0] rd_word;

  assign acc_wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign rd_setup = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
  assign wr_ctrl_one = acc_wr && (PADDR_IN == pcg_pkg::OFS_CTRL_ONE);
  assign mapped = (PADDR_IN == pcg_pkg::OFS_CTRL_ONE) || (PADDR_IN == pcg_pkg::OFS_CTRL_TWO) ||
                  (PADDR_IN == pcg_pkg::OFS_MASK_LOW) || (PADDR_IN == pcg_pkg::OFS_MASK_HIGH) ||
                  (PADDR_IN == pcg_pkg::OFS_DATA_LOW) || (PADDR_IN == pcg_pkg::OFS_DATA_HIGH) ||
                  (PADDR_IN == pcg_pkg::OFS_RES_LOW) || (PADDR_IN == pcg_pkg::OFS_RES_HIGH);
  assign depth = fifo_depth(state_reg.dw);
  assign full = state_reg.cnt >= depth;
  // The word is counted when the byte lane holding its top bit is written.
  assign hit_data = acc_wr && PSTRB_IN[state_reg.dw[3]] &&
                    (state_reg.dw[4] ? (PADDR_IN == pcg_pkg::OFS_DATA_HIGH)
                                     : (PADDR_IN == pcg_pkg::OFS_DATA_LOW));
  assign push = hit_data && !full && state_reg.en;

  // ---------------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_word = '0;
    unique case (PADDR_IN)
      pcg_pkg::OFS_CTRL_ONE: begin
        rd_word[pcg_pkg::EN_BIT] = state_reg.en;
        rd_word[pcg_pkg::VW_LSB +: pcg_pkg::FIELD_W] = state_reg.cnt;
        rd_word[pcg_pkg::FULL_BIT] = full;
        rd_word[pcg_pkg::EMPTY_BIT] = (state_reg.cnt == '0);
        rd_word[pcg_pkg::ISEL_BIT] = state_reg.isel;
        rd_word[pcg_pkg::GO_BIT] = state_reg.go;
        rd_word[pcg_pkg::DIR_BIT] = state_reg.dir;
      end
      pcg_pkg::OFS_CTRL_TWO: begin
        rd_word[pcg_pkg::DW_LSB +: pcg_pkg::FIELD_W] = state_reg.dw;
        rd_word[pcg_pkg::PLEN_LSB +: pcg_pkg::FIELD_W] = state_reg.plen;
      end
      pcg_pkg::OFS_MASK_LOW: begin
        rd_word[pcg_pkg::HALF_W-1:0] = state_reg.mask[15:0];
      end
      pcg_pkg::OFS_MASK_HIGH: begin
        rd_word[pcg_pkg::HALF_W-1:0] = state_reg.mask[31:16];
      end
      pcg_pkg::OFS_RES_LOW: begin
        rd_word[pcg_pkg::HALF_W-1:0] = state_reg.crc[15:0];
      end
      pcg_pkg::OFS_RES_HIGH: begin
        rd_word[pcg_pkg::HALF_W-1:0] = state_reg.crc[31:16];
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.irq = 1'b0;
    pop = 1'b0;

    // Shift engine. Clearing the start bit halts it mid-word so that a later
    // start resumes where it stopped.
    unique case (state_reg.eng)
      pcg_pkg::ENG_IDLE: begin
        if (state_reg.go && (state_reg.cnt != '0)) begin
          pop = 1'b1;
          state_next.eng = pcg_pkg::ENG_SHIFT;
        end
      end
      pcg_pkg::ENG_SHIFT: begin
        if (state_reg.go) begin
          for (int i = 0; i < pcg_pkg::BITS_PER_CYCLE; i++) begin
            if (state_next.left != '0) begin
              state_next.crc = crc_step(state_next.crc, state_reg.mask, state_reg.plen,
                                        next_bit(state_next.sh, state_reg.dw, state_reg.dir));
              state_next.sh = shift_buf(state_next.sh, state_reg.dir);
              state_next.left = state_next.left - pcg_pkg::LEFT_ONE;
            end
          end
          if (state_next.left == '0) begin
            if (state_reg.cnt != '0) begin
              pop = 1'b1;
            end else begin
              state_next.eng = pcg_pkg::ENG_IDLE;
              state_next.go = 1'b0;
              state_next.irq = state_reg.isel;
            end
          end
        end
      end
    endcase

    // Reloading on the last shift cycle keeps a word to width / 2 cycles, rounded up for odd widths.
    if (pop) begin
      state_next.sh = state_reg.mem[state_reg.rp];
      state_next.rp = state_reg.rp + pcg_pkg::PTR_ONE;
      state_next.left = {1'b0, state_reg.dw} + pcg_pkg::LEFT_ONE;
      // The last word still shifts for its own width after this pulse.
      if (!state_reg.isel && !push && (state_reg.cnt == pcg_pkg::CNT_ONE)) begin
        state_next.irq = 1'b1;
      end
    end
    if (push && !pop) begin
      state_next.cnt = state_reg.cnt + pcg_pkg::CNT_ONE;
    end else if (pop && !push) begin
      state_next.cnt = state_reg.cnt - pcg_pkg::CNT_ONE;
    end

    // Register writes come after the engine so that a write wins the cycle.
    if (acc_wr) begin
      unique case (PADDR_IN)
        pcg_pkg::OFS_CTRL_ONE: begin
          if (PSTRB_IN[1]) begin
            state_next.en = PWDATA_IN[pcg_pkg::EN_BIT];
          end
          if (PSTRB_IN[0]) begin
            state_next.isel = PWDATA_IN[pcg_pkg::ISEL_BIT];
            state_next.go = PWDATA_IN[pcg_pkg::GO_BIT];
            state_next.dir = PWDATA_IN[pcg_pkg::DIR_BIT];
          end
        end
        pcg_pkg::OFS_CTRL_TWO: begin
          if (PSTRB_IN[1]) begin
            state_next.dw = PWDATA_IN[pcg_pkg::DW_LSB +: pcg_pkg::FIELD_W];
          end
          if (PSTRB_IN[0]) begin
            state_next.plen = PWDATA_IN[pcg_pkg::PLEN_LSB +: pcg_pkg::FIELD_W];
          end
        end
        pcg_pkg::OFS_MASK_LOW: begin
          state_next.mask[15:0] = merge_half(state_reg.mask[15:0], PWDATA_IN[15:0],
                                             PSTRB_IN[1:0]);
          state_next.mask[0] = 1'b0;
        end
        pcg_pkg::OFS_MASK_HIGH: begin
          state_next.mask[31:16] = merge_half(state_reg.mask[31:16], PWDATA_IN[15:0],
                                              PSTRB_IN[1:0]);
        end
        pcg_pkg::OFS_DATA_LOW: begin
          if (!full) begin
            state_next.stage[15:0] = merge_half(state_reg.stage[15:0], PWDATA_IN[15:0],
                                                PSTRB_IN[1:0]);
          end
        end
        pcg_pkg::OFS_DATA_HIGH: begin
          if (!full) begin
            state_next.stage[31:16] = merge_half(state_reg.stage[31:16], PWDATA_IN[15:0],
                                                 PSTRB_IN[1:0]);
          end
        end
        pcg_pkg::OFS_RES_LOW: begin
          state_next.crc[15:0] = merge_half(state_next.crc[15:0], PWDATA_IN[15:0],
                                            PSTRB_IN[1:0]);
        end
        pcg_pkg::OFS_RES_HIGH: begin
          state_next.crc[31:16] = merge_half(state_next.crc[31:16], PWDATA_IN[15:0],
                                             PSTRB_IN[1:0]);
        end
        default: begin
          state_next.irq = state_next.irq;
        end
      endcase
    end

    // Bits above the data width stay in the word but never reach the engine.
    if (push) begin
      state_next.mem[state_reg.wp] = state_next.stage;
      state_next.wp = state_reg.wp + pcg_pkg::PTR_ONE;
    end

    // A disabled block holds its pointers, counter, engine and shifter cleared.
    if (!state_next.en) begin
      state_next.cnt = '0;
      state_next.wp = '0;
      state_next.rp = '0;
      state_next.go = 1'b0;
      state_next.eng = pcg_pkg::ENG_IDLE;
      state_next.left = '0;
      state_next.crc = '0;
      state_next.stage = '0;
      state_next.irq = 1'b0;
    end

    if (rd_setup) begin
      state_next.rdata = rd_word;
    end
  end

  // ---------------------------------------------------------------------------
  // State register and outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign PRDATA_OUT = state_reg.rdata;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;
  assign IRQ_OUT = state_reg.irq;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_two_bits_cycle:
  assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (state_reg.eng == pcg_pkg::ENG_SHIFT && state_reg.go && state_reg.en &&
     state_reg.left > 6'h02 && state_next.en && !acc_wr)
    |=> (state_reg.left == $past(state_reg.left) - 6'h02))
    else $error("Engine did not consume two bits in one cycle.");

  a_start_needs_data:
  assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (state_reg.eng == pcg_pkg::ENG_IDLE && (!state_reg.go || state_reg.cnt == '0))
    |=> (state_reg.eng == pcg_pkg::ENG_IDLE))
    else $error("Engine started without start bit or data.");

  a_pop_decrements:
  assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (state_reg.eng == pcg_pkg::ENG_IDLE && state_reg.go && state_reg.cnt != '0 &&
     !push && state_next.en)
    |=> (state_reg.cnt == $past(state_reg.cnt) - 5'h01) &&
        (state_reg.left == {1'b0, $past(state_reg.dw)} + 6'h01))
    else $error("Word transfer did not decrement count or load the buffer.");

  a_disable_clears:
  assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !state_reg.en |-> (state_reg.cnt == '0) && (state_reg.wp == state_reg.rp))
    else $error("Disabled block holds FIFO words.");

  a_full_refuse:
  assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (full && !state_reg.go && acc_wr && state_next.en)
    |=> (state_reg.cnt == $past(state_reg.cnt)) && (state_reg.stage == $past(state_reg.stage)))
    else $error("Write accepted while FIFO full.");

  a_irq_pulse:
  assert property (@(posedge CLK_IN) disable iff (RST_IN)
    IRQ_OUT |=> !IRQ_OUT)
    else $error("Interrupt held longer than one cycle.");

  a_done_irq:
  assert property (@(posedge CLK_IN) disable iff (RST_IN)
    ($fell(state_reg.go) && $past(state_reg.eng == pcg_pkg::ENG_SHIFT) &&
     $past(state_reg.isel) && !$past(wr_ctrl_one))
    |-> IRQ_OUT)
    else $error("Completion without interrupt in completion mode.");

  a_sw_clear_quiet:
  assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (wr_ctrl_one && PSTRB_IN[0] && !PWDATA_IN[pcg_pkg::GO_BIT] && state_reg.isel &&
     state_reg.eng == pcg_pkg::ENG_SHIFT && state_reg.left > 6'h02)
    |=> !IRQ_OUT && !state_reg.go)
    else $error("Software clear of start bit raised an interrupt.");

  a_empty_irq:
  assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (pop && !push && !state_reg.isel && state_reg.cnt == 5'h01 && state_next.en)
    |=> IRQ_OUT && (state_reg.cnt == '0))
    else $error("Count one-to-zero without interrupt in empty mode.");

  a_data_reads_zero:
  assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (rd_setup && (PADDR_IN == pcg_pkg::OFS_DATA_LOW || PADDR_IN == pcg_pkg::OFS_DATA_HIGH))
    |=> (PRDATA_OUT == '0))
    else $error("Data register read returned non-zero.");

endmodule : pcg_crc_top

// File: tb/pcg_crc_top_tb.sv
// Self-checking testbench for the programmable CRC generator.
`timescale 1ns/1ps

module pcg_crc_top_tb;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  int irq_count = 0;
  int waited;
  int i;
  int n0;
  logic [31:0] rd_val;
  logic err_val;
  logic [31:0] exp_crc;
  logic [31:0] w;
  logic [7:0] b;

  initial forever #5 clk = ~clk;

  pcg_crc_top dut (
    .CLK_IN(clk),
    .RST_IN(rst),
    .PSEL_IN(psel),
    .PENABLE_IN(penable),
    .PWRITE_IN(pwrite),
    .PADDR_IN(paddr),
    .PWDATA_IN(pwdata),
    .PSTRB_IN(pstrb),
    .PRDATA_OUT(prdata),
    .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr),
    .IRQ_OUT(irq)
  );

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task final_report;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // The ceiling sits far above the few hundred cycles the tests need.
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (irq === 1'b1) irq_count = irq_count + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      final_report();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One transfer; the request is held until pready is sampled high.
  task apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the bench timeout may end this wait.
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd_val = prdata;
    err_val = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask : wr

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000, 4'h0);
    chk(rd_val, exp);
  endtask : rchk

  task wait_irq;
    waited = 0;
    while (irq !== 1'b1 && waited < 200) begin
      @(posedge clk);
      waited++;
    end
    chk(32'(waited < 200), 32'h1);
  endtask : wait_irq

  function automatic logic [31:0] crc_model(input logic [31:0] c, input logic [31:0] dw,
      input int nb, input logic dir, input int pl, input logic [31:0] m);
    logic [31:0] lm;
    logic fb;
    lm = (pl == 31) ? 32'hffffffff : ((32'h1 << (pl + 1)) - 32'h1);
    for (int k = 0; k < nb; k++) begin
      fb = (dir ? dw[k] : dw[nb - 1 - k]) ^ c[pl];
      c = (c << 1) & lm;
      if (fb) c = c ^ ((m | 32'h1) & lm);
    end
    return c;
  endfunction : crc_model

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk(pcg_pkg::OFS_CTRL_ONE, 32'h00000040);
    wr(pcg_pkg::OFS_DATA_LOW, 32'h000000ff);
    rchk(pcg_pkg::OFS_CTRL_ONE, 32'h00000040);
    rchk(pcg_pkg::OFS_DATA_LOW, 32'h00000000);
    apb(1'b0, 8'h20, 32'h00000000, 4'h0);
    chk(32'(err_val), 32'h1);
    // Byte-wide words, 16-bit polynomial, MSb first, completion interrupt.
    wr(pcg_pkg::OFS_CTRL_ONE, 32'h00008020);
    wr(pcg_pkg::OFS_CTRL_TWO, 32'h0000070f);
    wr(pcg_pkg::OFS_MASK_LOW, 32'h00001021);
    wr(pcg_pkg::OFS_MASK_HIGH, 32'h00000001);
    rchk(pcg_pkg::OFS_CTRL_TWO, 32'h0000070f);
    rchk(pcg_pkg::OFS_MASK_LOW, 32'h00001020);
    exp_crc = 32'h0;
    for (i = 0; i < 16; i++) begin
      b = 8'(i * 37 + 5);
      apb(1'b1, pcg_pkg::OFS_DATA_LOW, {16'h0, 8'hff, b}, i[0] ? 4'h3 : 4'h1);
      exp_crc = crc_model(exp_crc, {24'h0, b}, 8, 1'b0, 15, 32'h00011021);
      if (i == 0) rchk(pcg_pkg::OFS_CTRL_ONE, 32'h00008120);
    end
    rchk(pcg_pkg::OFS_CTRL_ONE, 32'h000090a0);
    apb(1'b1, pcg_pkg::OFS_DATA_LOW, 32'h00000077, 4'h1);
    rchk(pcg_pkg::OFS_CTRL_ONE, 32'h000090a0);
    wr(pcg_pkg::OFS_CTRL_ONE, 32'h00008030);
    wait_irq();
    chk(32'(waited >= 60 && waited <= 70), 32'h1);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    rchk(pcg_pkg::OFS_CTRL_ONE, 32'h00008060);
    rchk(pcg_pkg::OFS_RES_LOW, {16'h0, exp_crc[15:0]});
    rchk(pcg_pkg::OFS_RES_HIGH, 32'h00000000);
    // Disable clears; then 32-bit words, 32-bit polynomial, LSb first.
    wr(pcg_pkg::OFS_CTRL_ONE, 32'h00000000);
    rchk(pcg_pkg::OFS_CTRL_ONE, 32'h00000040);
    wr(pcg_pkg::OFS_CTRL_ONE, 32'h00008008);
    wr(pcg_pkg::OFS_CTRL_TWO, 32'h00001f1f);
    wr(pcg_pkg::OFS_MASK_LOW, 32'h00001db7);
    wr(pcg_pkg::OFS_MASK_HIGH, 32'h000004c1);
    wr(pcg_pkg::OFS_RES_LOW, 32'h0000ffff);
    wr(pcg_pkg::OFS_RES_HIGH, 32'h0000ffff);
    rchk(pcg_pkg::OFS_RES_HIGH, 32'h0000ffff);
    rchk(pcg_pkg::OFS_CTRL_ONE, 32'h00008048);
    exp_crc = 32'hffffffff;
    for (i = 0; i < 4; i++) begin
      w = 32'h12345678 + i * 32'h01010101;
      wr(pcg_pkg::OFS_DATA_LOW, {16'h0, w[15:0]});
      if (i == 0) rchk(pcg_pkg::OFS_CTRL_ONE, 32'h00008048);
      wr(pcg_pkg::OFS_DATA_HIGH, {16'h0, w[31:16]});
      exp_crc = crc_model(exp_crc, w, 32, 1'b1, 31, 32'h04c11db7);
    end
    rchk(pcg_pkg::OFS_CTRL_ONE, 32'h00008488);
    n0 = irq_count;
    wr(pcg_pkg::OFS_CTRL_ONE, 32'h00008018);
    wait_irq();
    // The last word is still shifting after the empty interrupt.
    waited = 0;
    rd_val = 32'h00000010;
    while (rd_val[4] === 1'b1 && waited < 20) begin
      apb(1'b0, pcg_pkg::OFS_CTRL_ONE, 32'h00000000, 4'h0);
      waited++;
    end
    chk(32'(waited >= 2 && waited <= 8), 32'h1);
    chk(rd_val, 32'h00008048);
    rchk(pcg_pkg::OFS_RES_LOW, {16'h0, exp_crc[15:0]});
    rchk(pcg_pkg::OFS_RES_HIGH, {16'h0, exp_crc[31:16]});
    chk(32'(irq_count - n0), 32'h1);
    // Software stop in mid-word must stay silent.
    wr(pcg_pkg::OFS_DATA_LOW, 32'h0000aaaa);
    wr(pcg_pkg::OFS_DATA_HIGH, 32'h00005555);
    wr(pcg_pkg::OFS_CTRL_ONE, 32'h00008030);
    wr(pcg_pkg::OFS_CTRL_ONE, 32'h00008020);
    repeat (40) @(posedge clk);
    chk(32'(irq_count - n0), 32'h1);
    rchk(pcg_pkg::OFS_CTRL_ONE, 32'h00008060);
    final_report();
  end
endmodule : pcg_crc_top_tb
